//--- hw/wdsw_consts.svh
// offsets, field positions, reset values and timing counts of the block
`ifndef WDSW_CONSTS_SVH
`define WDSW_CONSTS_SVH

// ====================================================================
// register offsets
`define WDSW_OPT_ADDR    4'h0
`define WDSW_STAT_ADDR   4'h1

// ====================================================================
// reset values
`define WDSW_OPT_RESET   8'hff
`define WDSW_PORB_RESET  3'h3

// ====================================================================
// field positions
`define WDSW_OPT_WOC     7
`define WDSW_OPT_PSA     3
`define WDSW_STAT_PWF    7
`define WDSW_STAT_TO     4
`define WDSW_STAT_PD     3
`define WDSW_STAT_SLEEP  0

// ====================================================================
// timing
`define WDSW_WDT_PERIOD_US 18000
`define WDSW_CLK_MHZ       50

// ====================================================================
// verify and serial programming
`define WDSW_FREE_WORDS  11'h040
`define WDSW_OSC_CALIBRATION_WORD_ADDR 11'h3ff
`define WDSW_ID_BASE     11'h400
`define WDSW_CMD_LOAD    6'h02
`define WDSW_CMD_READ    6'h04
`define WDSW_CMD_INCR    6'h06
`define WDSW_CMD_LAST    4'h5
`define WDSW_DATA_LAST   4'hd

`endif

//--- hw/wdsw_pkg.sv
// types of the watchdog, sleep and wake-up block
package wdsw_pkg;

  // ==================================================================
  // serial programming states
  typedef enum logic [2:0] {
    WDSW_PS_CMD  = 3'b001,
    WDSW_PS_LOAD = 3'b010,
    WDSW_PS_READ = 3'b100
  } wdsw_pstate_t;

  // ==================================================================
  // whole state of the block
  typedef struct packed {
    logic [7:0]        option;
    logic              pin_wake;
    logic              to;
    logic              pd;
    logic              sleeping;
    logic [19:0]       wdt_cnt;
    logic [7:0]        pre_cnt;
    logic [3:0]        pin_latch;
    logic              rst_out;
    logic [7:0]        rdata;
    logic              prog_mode;
    logic              vpp_q;
    logic              clk_q;
    wdsw_pstate_t      pst;
    logic [3:0]        bit_cnt;
    logic [13:0]       shreg;
    logic [10:0]       addr;
    logic [3:0][13:0]  id;
    logic              pm_we;
    logic [11:0]       pm_wdata;
    logic              dout;
    logic              doe;
  } wdsw_state_t;

endpackage

//--- hw/wdsw_top.sv
// watchdog, sleep, wake-up, reset-cause flags and serial programming
`timescale 1ns/100ps
`include "wdsw_consts.svh"

module wdsw_top #(
  parameter int unsigned WDT_CYCLES = `WDSW_WDT_PERIOD_US * `WDSW_CLK_MHZ
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  // register port
  input  wire logic [3:0]   reg_addr,
  input  wire logic [7:0]   reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic      [7:0]   reg_rdata,
  // processor events and configuration
  input  wire logic         clear_watchdog_instr,
  input  wire logic         sleep_instr,
  input  wire logic         portb_access,
  input  wire logic         watchdog_enable,
  input  wire logic         reset_pin_enable,
  input  wire logic         code_protect,
  // pins
  input  wire logic         external_reset_pin_b,
  input  wire logic         programming_high_level,
  input  wire logic [5:0]   port_b_in,
  output logic              prog_data_out,
  output logic              prog_data_oe,
  // program memory
  output logic      [10:0]  pm_addr,
  input  wire logic [11:0]  pm_rdata,
  output logic              pm_we,
  output logic      [11:0]  pm_wdata,
  // device control
  output logic              device_reset,
  output logic              sleeping,
  output logic              osc_driver_off,
  output logic              port_hold,
  output logic              prog_mode
);
  import wdsw_pkg::*;

  // ==================================================================
  // register map
  // option at offset 0: write only, reads back as zero
  // status at offset 1: read only, writes ignored
  // unmapped offsets read zero and swallow writes
  // read data stands one cycle after the strobe, zero otherwise
  // write data lands at the strobe edge, visible the next cycle

  // ==================================================================
  // status layout
  // bit 7: pin wake flag, set only by a pin-change wake
  // bit 4: timeout flag, low after a watchdog timeout
  // bit 3: powerdown flag, low after a sleep instruction
  // bit 0: sleeping, high between sleep entry and wake
  // other bits read zero

  // ==================================================================
  // option layout
  // bit 7: wake-on-change disable, high blocks pin wake
  // bit 3: prescaler assign, high hands prescaler to watchdog
  // bits 2:0: prescale select, ratio is two to that power
  // remaining bits stored but unused here
  // every wake or reset source and power-up puts all ones back, programming mode does not

  // ==================================================================
  // watchdog timing
  // one count per prescaler hit, timeout at the last count
  // prescaler unassigned: hit on every clock
  // prescaler assigned: hit once per ratio clocks
  // timeout period scales by the ratio, up to 1:128
  // count runs awake and asleep while enabled
  // enable low freezes the count and blocks timeouts
  // counter is 20 bits: period must fit below 2^20 cycles

  // ==================================================================
  // clear and sleep instructions
  // clear zeroes counter, prescaler only when assigned
  // sleep zeroes the same, so a full period precedes a wake
  // sleep while already asleep is ignored
  // clear in the timeout cycle still loses to the timeout

  // ==================================================================
  // wake and reset sources
  // priority: reset pin, then watchdog, then pin change
  // watchdog and pin change each pulse the internal reset for one cycle
  // reset pin holds the internal reset while low
  // all sources wake from sleep and restart the watchdog
  // internal reset is an output only, never drives the pin

  // ==================================================================
  // reset cause codes, wake / timeout / powerdown
  // watchdog while asleep: 0 0 0
  // watchdog while awake: 0 0 unchanged
  // reset pin: 0, timeout and powerdown unchanged
  // pin change while asleep: 1 1 0
  // power-up: 0 1 1
  // flags otherwise hold until the next reset event or sleep instruction

  // ==================================================================
  // pin change detection
  // watched pins are port b bits 0, 1, 3 and 4
  // latch refreshed by every file or bit access to port b
  // compare is level based against the latch, not edge based
  // hazard: stale latch before sleep wakes at once
  // software must read the pins right before sleeping

  // ==================================================================
  // programming entry and exit
  // entry on the rising edge of the high level sample
  // clock and data pins must both be low at that edge
  // mode holds the core in reset and ends any sleep
  // level dropping leaves the mode and frees the data pin
  // address starts at zero on every entry

  // ==================================================================
  // serial commands
  // six command bits then fourteen data bits, lsb first
  // bits taken on each sampled rising edge of the clock pin
  // load: fourteen bits in, then one write pulse or id store
  // read: first bit out after the last command edge
  // read: each later rise shifts out the next bit
  // increment: address steps by one, no data phase
  // unknown codes are dropped without side effects

  // ==================================================================
  // protection and id words
  // protected reads return zero above the free window, except the id words
  // free window: first 64 words and the calibration word
  // four id words sit just above program memory
  // id words only reachable in programming mode

  // ==================================================================
  // helpers
  function automatic logic [3:0] watched(input logic [5:0] pins);
    watched = {pins[4], pins[3], pins[1], pins[0]};
  endfunction

  function automatic logic [19:0] bump20(input logic [19:0] v);
    bump20 = v + 20'h0_0001;
  endfunction

  localparam logic [19:0] WDT_LAST = 20'(WDT_CYCLES - 1);

  wdsw_state_t s_ff;
  wdsw_state_t nxt_s;

  logic [7:0]  ratio_last;
  logic        pre_hit;
  logic        wdt_to;
  logic        pin_chg;
  logic        ext_rst;
  logic [3:0]  cur_pins;
  logic        prog_rise;
  logic        in_id;
  logic [13:0] read_word;
  logic [13:0] word_in;
  logic [5:0]  cmd_in;

  // ==================================================================
  // next state
  always_comb begin
    nxt_s       = s_ff;
    nxt_s.pm_we = 1'b0;
    nxt_s.rdata = 8'h00;
    cur_pins    = watched(port_b_in);

    // register port
    if (reg_rd && reg_addr == `WDSW_STAT_ADDR) begin
      nxt_s.rdata[`WDSW_STAT_PWF]   = s_ff.pin_wake;
      nxt_s.rdata[`WDSW_STAT_TO]    = s_ff.to;
      nxt_s.rdata[`WDSW_STAT_PD]    = s_ff.pd;
      nxt_s.rdata[`WDSW_STAT_SLEEP] = s_ff.sleeping;
    end
    if (reg_wr && reg_addr == `WDSW_OPT_ADDR) begin
      nxt_s.option = reg_wdata;
    end

    // ratio is two to the select value
    ratio_last = (8'h01 << s_ff.option[2:0]) - 8'h01;
    pre_hit    = !s_ff.option[`WDSW_OPT_PSA] || s_ff.pre_cnt == ratio_last;
    nxt_s.pre_cnt = pre_hit ? 8'h00 : s_ff.pre_cnt + 8'h01;

    wdt_to = watchdog_enable && pre_hit && s_ff.wdt_cnt == WDT_LAST;
    if (watchdog_enable && pre_hit) begin
      nxt_s.wdt_cnt = wdt_to ? 20'h0_0000 : bump20(s_ff.wdt_cnt);
    end

    // latch pins at each port access
    if (portb_access) begin
      nxt_s.pin_latch = cur_pins;
    end
    // compare against latch, no edge needed
    pin_chg = s_ff.sleeping && !s_ff.option[`WDSW_OPT_WOC]
              && cur_pins != s_ff.pin_latch;
    ext_rst = reset_pin_enable && !external_reset_pin_b && !s_ff.prog_mode;

    if (clear_watchdog_instr) begin
      nxt_s.wdt_cnt = 20'h0_0000;
      if (s_ff.option[`WDSW_OPT_PSA]) begin
        nxt_s.pre_cnt = 8'h00;
      end
    end
    if (sleep_instr && !s_ff.sleeping) begin
      nxt_s.wdt_cnt = 20'h0_0000;
      if (s_ff.option[`WDSW_OPT_PSA]) begin
        nxt_s.pre_cnt = 8'h00;
      end
      nxt_s.to       = 1'b1;
      nxt_s.pd       = 1'b0;
      nxt_s.sleeping = 1'b1;
    end

    // wake and reset sources, reset pin first
    if (ext_rst || wdt_to || pin_chg) begin
      nxt_s.sleeping = 1'b0;
      nxt_s.option   = `WDSW_OPT_RESET;
      nxt_s.wdt_cnt  = 20'h0_0000;
      nxt_s.pre_cnt  = 8'h00;
    end
    if (ext_rst) begin
      // reset pin keeps timeout and powerdown
      // reset pin codes start with wake flag low
      nxt_s.pin_wake = 1'b0;
    end else if (wdt_to) begin
      nxt_s.pin_wake = 1'b0;
      nxt_s.to       = 1'b0;
      nxt_s.pd       = s_ff.sleeping ? 1'b0 : s_ff.pd;
    end else if (pin_chg) begin
      nxt_s.pin_wake = 1'b1;
      nxt_s.to       = 1'b1;
      nxt_s.pd       = 1'b0;
    end

    // ================================================================
    // serial programming
    nxt_s.vpp_q = programming_high_level;
    nxt_s.clk_q = port_b_in[1];
    prog_rise   = s_ff.prog_mode && port_b_in[1] && !s_ff.clk_q;
    word_in     = {port_b_in[0], s_ff.shreg[13:1]};
    cmd_in      = {port_b_in[0], s_ff.shreg[13:9]};
    in_id       = s_ff.addr[10:2] == `WDSW_ID_BASE >> 2;

    if (in_id) begin
      read_word = s_ff.id[s_ff.addr[1:0]];
    end else if (code_protect && s_ff.addr >= `WDSW_FREE_WORDS
                 && s_ff.addr != `WDSW_OSC_CALIBRATION_WORD_ADDR) begin
      read_word = 14'h0000;
    end else begin
      read_word = {2'b00, pm_rdata};
    end

    // entry with clock and data low
    if (programming_high_level && !s_ff.vpp_q
        && !port_b_in[1] && !port_b_in[0]) begin
      nxt_s.prog_mode = 1'b1;
      nxt_s.pst       = WDSW_PS_CMD;
      nxt_s.bit_cnt   = 4'h0;
      nxt_s.addr      = 11'h000;
      nxt_s.sleeping  = 1'b0;
    end else if (!programming_high_level) begin
      nxt_s.prog_mode = 1'b0;
      nxt_s.pst       = WDSW_PS_CMD;
      nxt_s.bit_cnt   = 4'h0;
      nxt_s.doe       = 1'b0;
      nxt_s.dout      = 1'b0;
    end else if (prog_rise) begin
      nxt_s.bit_cnt = s_ff.bit_cnt + 4'h1;
      unique case (s_ff.pst)
        WDSW_PS_CMD: begin
          nxt_s.shreg = word_in;
          if (s_ff.bit_cnt == `WDSW_CMD_LAST) begin
            nxt_s.bit_cnt = 4'h0;
            if (cmd_in == `WDSW_CMD_LOAD) begin
              nxt_s.pst = WDSW_PS_LOAD;
            end else if (cmd_in == `WDSW_CMD_READ) begin
              nxt_s.pst   = WDSW_PS_READ;
              nxt_s.shreg = read_word;
              nxt_s.dout  = read_word[0];
              nxt_s.doe   = 1'b1;
            end else if (cmd_in == `WDSW_CMD_INCR) begin
              nxt_s.addr = s_ff.addr + 11'h001;
            end
          end
        end
        WDSW_PS_LOAD: begin
          nxt_s.shreg = word_in;
          if (s_ff.bit_cnt == `WDSW_DATA_LAST) begin
            nxt_s.bit_cnt = 4'h0;
            nxt_s.pst     = WDSW_PS_CMD;
            if (in_id) begin
              nxt_s.id[s_ff.addr[1:0]] = word_in;
            end else begin
              nxt_s.pm_we    = 1'b1;
              nxt_s.pm_wdata = word_in[11:0];
            end
          end
        end
        WDSW_PS_READ: begin
          nxt_s.shreg = {1'b0, s_ff.shreg[13:1]};
          nxt_s.dout  = s_ff.shreg[1];
          if (s_ff.bit_cnt == `WDSW_DATA_LAST) begin
            nxt_s.bit_cnt = 4'h0;
            nxt_s.pst     = WDSW_PS_CMD;
            nxt_s.doe     = 1'b0;
            nxt_s.dout    = 1'b0;
          end
        end
      endcase
    end

    // internal reset only, no pin drive
    nxt_s.rst_out = ext_rst || wdt_to || pin_chg || nxt_s.prog_mode;
  end

  // ==================================================================
  // state register
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s_ff           <= '0;
      s_ff.option    <= `WDSW_OPT_RESET;
      {s_ff.pin_wake, s_ff.to, s_ff.pd} <= `WDSW_PORB_RESET;
      s_ff.pst       <= WDSW_PS_CMD;
      s_ff.rst_out   <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==================================================================
  // outputs
  assign reg_rdata      = s_ff.rdata;
  assign prog_data_out  = s_ff.dout;
  assign prog_data_oe   = s_ff.doe;
  assign pm_addr        = s_ff.addr;
  assign pm_we          = s_ff.pm_we;
  assign pm_wdata       = s_ff.pm_wdata;
  assign device_reset   = s_ff.rst_out;
  assign sleeping       = s_ff.sleeping;
  assign osc_driver_off = s_ff.sleeping;
  assign port_hold      = s_ff.sleeping;
  assign prog_mode      = s_ff.prog_mode;

endmodule

//--- sim/tb.sv
// testbench of the watchdog, sleep and programming block
`timescale 1ns/100ps
module tb;
  import wdsw_pkg::*;
  localparam int W = 40;
  logic        ref_clk, rst_b, reg_wr, reg_rd, prog_mode, sleeping;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, d;
  logic        clear_watchdog_instr, sleep_instr, portb_access;
  logic        watchdog_enable, reset_pin_enable, code_protect;
  logic        external_reset_pin_b, programming_high_level;
  logic [5:0]  port_b_in, pins;
  logic        prog_data_out, prog_data_oe, pm_we, device_reset;
  logic        osc_driver_off, port_hold, pclk, pdat;
  logic [10:0] pm_addr;
  logic [11:0] pm_rdata, pm_wdata;
  logic [13:0] w;
  int          fails, tests_run, n, we_cnt;
  assign pm_rdata = 12'hfff ^ {1'b0, pm_addr};
  assign port_b_in = prog_mode ? {pins[5:2], pclk,
    prog_data_oe ? prog_data_out : pdat} : pins;
  wdsw_top #(.WDT_CYCLES(W)) dut (.ref_clk, .rst_b, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .clear_watchdog_instr,
    .sleep_instr, .portb_access, .watchdog_enable, .reset_pin_enable,
    .code_protect, .external_reset_pin_b, .programming_high_level,
    .port_b_in, .prog_data_out, .prog_data_oe, .pm_addr, .pm_rdata,
    .pm_we, .pm_wdata, .device_reset, .sleeping, .osc_driver_off,
    .port_hold, .prog_mode);
  wdsw_prog_model pm (.ref_clk, .pdat_in(port_b_in[0]), .pclk, .pdat);
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (pm_we === 1'b1) we_cnt++;
  // ==================================================================
  // bus, compare and closing tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
    @(posedge ref_clk);
  endtask
  task automatic pulse(input int k);
    if (k == 0) clear_watchdog_instr <= 1'b1;
    else if (k == 1) sleep_instr <= 1'b1;
    else portb_access <= 1'b1;
    @(posedge ref_clk);
    {clear_watchdog_instr, sleep_instr, portb_access} <= 3'b000;
    @(posedge ref_clk);
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      $display("wrong value at %0t: %h not %h", $time, g, e);
      fails++;
    end
  endtask
  task automatic chkn(input int g, input int lo, input int hi);
    chk8({7'h0, g >= lo && g <= hi}, 8'h01);
  endtask
  task automatic waitrst();
    n = 0;
    while (device_reset !== 1'b1 && n < 20000) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==================================================================
  // scenarios
  task automatic t_por();
    rd(4'h1);
    chk8(d, 8'h18);
    rd(4'h0);
    chk8(d, 8'h00);
    rd(4'hf);
    chk8(d, 8'h00);
  endtask
  task automatic t_wdt();
    for (int i = 0; i < 9; i++) begin
      wr(4'h0, i == 0 ? 8'h00 : {5'h01, 3'(i - 1)});
      pulse(0);
      waitrst();
      n = n - 3;
      chkn(n, (W - 1) * (1 << (i == 0 ? 0 : i - 1)) - 2,
        (W + 1) * (1 << (i == 0 ? 0 : i - 1)) + 2);
      rd(4'h1);
      chk8(d, 8'h08);
    end
  endtask
  task automatic t_clr();
    wr(4'h0, 8'h00);
    n = 0;
    repeat (6) begin
      pulse(0);
      repeat (W / 2) @(posedge ref_clk) n += device_reset;
    end
    chkn(n, 0, 0);
  endtask
  task automatic t_sleep_wdt();
    wr(4'h0, 8'h00);
    pulse(0);
    repeat (W / 2) @(posedge ref_clk);
    pulse(1);
    rd(4'h1);
    chk8(d, 8'h11);
    chk8({7'h0, osc_driver_off}, 8'h01);
    waitrst();
    chkn(n, W - 8, W + 2);
    rd(4'h1);
    chk8(d, 8'h00);
  endtask
  task automatic t_pin();
    watchdog_enable <= 1'b0;
    wr(4'h0, 8'h00);
    pulse(2);
    pulse(1);
    repeat (5) @(posedge ref_clk);
    chk8({7'h0, sleeping}, 8'h01);
    pins <= 6'h10;
    waitrst();
    chkn(n, 0, 3);
    rd(4'h1);
    chk8(d, 8'h90);
    wr(4'h0, 8'h00);
    pulse(1);
    waitrst();
    chkn(n, 0, 3);
  endtask
  task automatic t_rst_pin();
    reset_pin_enable <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      if (i == 1) pulse(1);
      external_reset_pin_b <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk8({7'h0, device_reset}, 8'h01);
      external_reset_pin_b <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rd(4'h1);
      chk8(d, 8'h10);
    end
  endtask
  task automatic t_prog();
    pins <= 6'h00;
    code_protect <= 1'b1;
    programming_high_level <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk8({7'h0, prog_mode}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      if (i == 1) repeat (64) pm.cmd(6'h06);
      if (i == 2) code_protect <= 1'b0;
      pm.cmd(6'h04);
      pm.get(w);
      chk8({7'h0, w != 14'h0}, {7'h0, i != 1});
    end
    n = we_cnt;
    pm.cmd(6'h02);
    pm.word(14'h001e);
    repeat (3) @(posedge ref_clk);
    chkn(we_cnt - n, 1, 1);
    programming_high_level <= 1'b0;
  endtask
  // ==================================================================
  // main sequence and watchdog
  initial begin
    {ref_clk, rst_b, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {clear_watchdog_instr, sleep_instr, portb_access} = '0;
    {reset_pin_enable, code_protect, programming_high_level} = '0;
    {watchdog_enable, external_reset_pin_b, pins} = 8'hc0;
    {fails, tests_run, we_cnt} = '0;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    t_por();
    t_wdt();
    t_clr();
    t_sleep_wdt();
    t_pin();
    t_rst_pin();
    t_prog();
    end_sim();
  end
  initial begin
    #1_000_000;
    fails++;
    end_sim();
  end
endmodule

//--- sim/wdsw_chk_assertions.sv
// port checker of the watchdog, sleep and programming block
`timescale 1ns/100ps
module wdsw_chk (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_b,
  // register port
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // events and pins
  input wire logic       sleep_instr,
  input wire logic       reset_pin_enable,
  input wire logic       external_reset_pin_b,
  input wire logic       programming_high_level,
  input wire logic [5:0] port_b_in,
  // outputs
  input wire logic       prog_data_oe,
  input wire logic       pm_we,
  input wire logic       device_reset,
  input wire logic       sleeping,
  input wire logic       osc_driver_off,
  input wire logic       port_hold,
  input wire logic       prog_mode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // ==================================================================
  // port relations
  a_rd_slot: assert property (
    reg_rdata != 8'h00 |-> $past(reg_rd)) else $error("data off slot");
  a_sleep_entry: assert property (
    sleep_instr && !sleeping && !device_reset && !prog_mode
    |=> sleeping && osc_driver_off) else $error("sleep not entered");
  a_sleep_hold: assert property (
    sleeping |-> port_hold && osc_driver_off) else $error("pins not held");
  a_wake_reset: assert property (
    $fell(sleeping) |-> device_reset) else $error("wake without reset");
  a_pin_reset: assert property (
    reset_pin_enable && !external_reset_pin_b && !prog_mode
    |=> device_reset) else $error("reset pin ignored");
  a_prog_entry: assert property (
    $rose(programming_high_level) && port_b_in[1:0] == 2'b00
    |=> prog_mode) else $error("no program mode");
  a_prog_reset: assert property (
    prog_mode |-> device_reset) else $error("program mode runs");
  a_we_pulse: assert property (
    pm_we |=> !pm_we) else $error("write strobe too long");
  a_oe_mode: assert property (
    prog_data_oe |-> prog_mode) else $error("data driven outside mode");
endmodule

bind wdsw_top wdsw_chk u_chk (.ref_clk, .rst_b, .reg_rd, .reg_rdata,
  .sleep_instr, .reset_pin_enable, .external_reset_pin_b,
  .programming_high_level, .port_b_in, .prog_data_oe, .pm_we,
  .device_reset, .sleeping, .osc_driver_off, .port_hold, .prog_mode);

//--- sim/wdsw_prog_model.sv
// serial programmer model on the clock and data pins
`timescale 1ns/100ps
module wdsw_prog_model (
  // clock
  input  wire logic ref_clk,
  // serial pins
  input  wire logic pdat_in,
  output logic      pclk,
  output logic      pdat
);
  initial begin
    pclk = 1'b0;
    pdat = 1'b0;
  end
  task automatic put(input logic b);
    pdat <= b;
    repeat (2) @(posedge ref_clk);
    pclk <= 1'b1;
    repeat (2) @(posedge ref_clk);
    pclk <= 1'b0;
  endtask
  task automatic cmd(input logic [5:0] c);
    for (int i = 0; i < 6; i++) put(c[i]);
  endtask
  task automatic word(input logic [13:0] w);
    for (int i = 0; i < 14; i++) put(w[i]);
  endtask
  task automatic get(output logic [13:0] w);
    for (int i = 0; i < 14; i++) begin
      @(negedge ref_clk);
      w[i] = pdat_in;
      put(~pdat_in);
    end
  endtask
endmodule
